/* File: dv/ppd_link_partner.sv */
// System controller end of the control link, driving the link input.
// Assumes clk_sys; the bench asks for link states as levels.
`timescale 1ns/1ps
`default_nettype none
module ppd_link_partner (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // Requested link state from the bench
   input wire logic [3:0] want,
   // Link input of the device
   output ppd_pkg::ppd_link_in_s link_in
);
   ppd_pkg::ppd_link_in_s next_link_in;
   always_comb begin
      next_link_in = want;
      if (reset) begin
         next_link_in = '0;
      end
   end
   always_ff @(posedge clk_sys) begin
      link_in <= next_link_in;
   end
endmodule
`default_nettype wire

/* File: dv/ppd_top_props.sv */
// Checker for the port decoder: decode map, data drive and pin relations.
// Assumes binding into ppd_top, one clk_sys domain.
`timescale 1ns/1ps
`default_nettype none
module ppd_top_props (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // I/O cycle
   input wire ppd_pkg::ppd_io_req_s io_req,
   input wire logic io_rdata_oe,
   input wire ppd_pkg::ppd_sel_e io_sel,
   // Pins
   input wire logic [15:0] irq_pins,
   input wire logic [15:0] int_lines,
   input wire logic power_good_input,
   input wire logic rtc_alarm,
   input wire logic alarm_pin_out,
   input wire logic alarm_pin_oe,
   input wire logic address_line_gate,
   input wire logic address_wrap_mask_output
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);
   logic [15:0] a;
   assign a = io_req.addr;
   sequence s_hit;
      io_req.rd && !(io_sel inside {ppd_pkg::SEL_NONE, ppd_pkg::SEL_ERR});
   endsequence
   sequence s_miss;
      io_req.rd && io_sel inside {ppd_pkg::SEL_NONE, ppd_pkg::SEL_ERR};
   endsequence
   a_miss_no_drive: assert property (s_miss |=> !io_rdata_oe)
      else $error("unmapped read drove the data bus");
   a_hit_drives: assert property (s_hit |=> io_rdata_oe)
      else $error("mapped read left the data bus undriven");
   a_cfg_pairs: assert property ((a inside {16'h0022, 16'h0023} |->
      io_sel == ppd_pkg::SEL_CFG) and (a inside {16'h0026, 16'h0027}
      |-> io_sel == ppd_pkg::SEL_SMM)) else $error("config pair decode");
   a_rtc_ports: assert property ((a == 16'h0070 |->
      io_sel == ppd_pkg::SEL_RTC_ADR) and (a == 16'h0071 |->
      io_sel == ppd_pkg::SEL_RTC_DAT)) else $error("clock port decode");
   a_fast_port: assert property (a == 16'h0092 |->
      io_sel == ppd_pkg::SEL_FAST) else $error("fast port decode");
   a_pic_ports: assert property ((a[15:1] == 15'h0010 |->
      io_sel == ppd_pkg::SEL_PIC1) and (a[15:1] == 15'h0050 |->
      io_sel == ppd_pkg::SEL_PIC2)) else $error("controller decode");
   a_dma_ports: assert property ((a inside {[16'h00C0:16'h00DF]} |->
      io_sel == ppd_pkg::SEL_DMA2) and (a inside {[16'h0080:16'h008F]}
      |-> io_sel == ppd_pkg::SEL_PAGE)) else $error("dma decode");
   a_alarm_drive: assert property ((!power_good_input && rtc_alarm)[*5]
      |-> alarm_pin_oe && !alarm_pin_out) else $error("alarm not driven");
   a_alarm_float: assert property (power_good_input[*5]
      |-> !alarm_pin_oe) else $error("alarm pin driven with power good");
   a_gate_or: assert property (address_line_gate[*5]
      |-> address_wrap_mask_output) else $error("gate not in wrap mask");
   a_irq_follow: assert property ($stable(irq_pins)[*5] |->
      (int_lines & 16'hDEFF) == (irq_pins & 16'hDEFF))
      else $error("request lines do not follow pins");
endmodule
bind ppd_top ppd_top_props ppd_top_props_inst (.clk_sys(clk_sys),
   .reset(reset), .io_req(io_req), .io_rdata_oe(io_rdata_oe),
   .io_sel(io_sel), .irq_pins(irq_pins), .int_lines(int_lines),
   .power_good_input(power_good_input), .rtc_alarm(rtc_alarm),
   .alarm_pin_out(alarm_pin_out), .alarm_pin_oe(alarm_pin_oe),
   .address_line_gate(address_line_gate),
   .address_wrap_mask_output(address_wrap_mask_output));
`default_nettype wire

/* File: dv/test_ppd_top.sv */
// Self-checking bench for ppd_top: APB, I/O decode, pins, control link.
// Assumes the partner model and the bound checker are compiled before.
`timescale 1ns/1ps
`default_nettype none
module test_ppd_top;
   logic clk_sys = '0, reset = '1, psel = '0, penable = '0, pwrite = '0;
   logic pready, pslverr, io_rdata_oe, irq, ext = '0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rdv, r, seed = 32'h77D0;
   ppd_pkg::ppd_io_req_s io_req = '0;
   ppd_pkg::ppd_sel_e io_sel;
   logic [7:0] io_rdata, unit_rdata = '0, p61 = '0;
   logic [15:0] irq_pins = '0, int_lines, ex;
   logic rtc_pin_shared_irq_eight = '1, fpu_error_input = '0;
   logic power_good_input = '1, rtc_alarm = '0, address_line_gate = '0;
   logic internal_ignore = '0, timer2_out = '0;
   logic fpu_error_internal, ignore_numeric_error_output, alarm_pin_out;
   logic alarm_pin_oe, tone_output, address_wrap_mask_output;
   logic fast_reset, nmi_mask;
   logic [3:0] link_side_events = '0, want = '0;
   ppd_pkg::ppd_link_out_s control_link_out;
   ppd_pkg::ppd_link_in_s control_link_in;
   int n_fail = 0, checks = 0;
   int tbl[] = '{0, 15, 16, 32, 33, 34, 35, 36, 38, 39, 64, 67, 68, 96, 97,
      100, 112, 113, 114, 128, 143, 144, 146, 160, 161, 162, 191, 192, 223,
      224, 240, 241, 242, 256};
   ppd_top ppd_top_inst (.clk_sys(clk_sys), .reset(reset), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .io_req(io_req),
      .io_rdata(io_rdata), .io_rdata_oe(io_rdata_oe), .io_sel(io_sel),
      .unit_rdata(unit_rdata), .irq_pins(irq_pins),
      .rtc_pin_shared_irq_eight(rtc_pin_shared_irq_eight),
      .fpu_error_input(fpu_error_input),
      .power_good_input(power_good_input), .rtc_alarm(rtc_alarm),
      .address_line_gate(address_line_gate),
      .link_side_events(link_side_events),
      .internal_ignore(internal_ignore), .int_lines(int_lines),
      .fpu_error_internal(fpu_error_internal),
      .ignore_numeric_error_output(ignore_numeric_error_output),
      .alarm_pin_out(alarm_pin_out), .alarm_pin_oe(alarm_pin_oe),
      .tone_output(tone_output), .timer2_out(timer2_out),
      .address_wrap_mask_output(address_wrap_mask_output),
      .fast_reset(fast_reset), .nmi_mask(nmi_mask),
      .control_link_out(control_link_out),
      .control_link_in(control_link_in), .irq(irq));
   ppd_link_partner ppd_link_partner_inst (.clk_sys(clk_sys),
      .reset(reset), .want(want), .link_in(control_link_in));
   always #4 clk_sys = ~clk_sys;
   task automatic finish_test();
      $display("checks=%0d n_fail=%0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         n_fail++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic ppd_pkg::ppd_sel_e es_of(input logic [15:0] a);
      if (a <= 16'h000F) return ppd_pkg::SEL_DMA1;
      if (a inside {16'h0020, 16'h0021}) return ppd_pkg::SEL_PIC1;
      if (a inside {16'h0022, 16'h0023}) return ppd_pkg::SEL_CFG;
      if (a inside {16'h0026, 16'h0027}) return ppd_pkg::SEL_SMM;
      if (a inside {[16'h0040:16'h0043]}) return ppd_pkg::SEL_TMR;
      if (a == 16'h0060) return ppd_pkg::SEL_KBD;
      if (a == 16'h0061) return ppd_pkg::SEL_SYS;
      if (a == 16'h0070) return ppd_pkg::SEL_RTC_ADR;
      if (a == 16'h0071) return ppd_pkg::SEL_RTC_DAT;
      if (a inside {[16'h0080:16'h008F]}) return ppd_pkg::SEL_PAGE;
      if (a == 16'h0092) return ppd_pkg::SEL_FAST;
      if (a inside {16'h00A0, 16'h00A1}) return ppd_pkg::SEL_PIC2;
      if (a inside {[16'h00C0:16'h00DF]}) return ppd_pkg::SEL_DMA2;
      if (a inside {16'h00F0, 16'h00F1}) return ppd_pkg::SEL_ERR;
      return ppd_pkg::SEL_NONE;
   endfunction
   task automatic wt(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic apb(input logic w, input logic [11:0] ad,
         input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge clk_sys);
      psel <= '1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= wd;
      @(posedge clk_sys);
      penable <= '1;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'h1 && n < 50);
      if (n >= 50) begin
         n_fail++;
         finish_test();
      end
      rdv = prdata;
      chk(pslverr, 0);
      psel <= '0;
      penable <= '0;
      if (w && ad == ppd_pkg::OFS_CTRL) ext = wd[ppd_pkg::CTRL_EXT_ERR];
   endtask
   task automatic io(input logic [15:0] ad, input logic w,
         input logic [7:0] d);
      ppd_pkg::ppd_sel_e es;
      logic ii, dr;
      es = es_of(ad);
      dr = !w && !(es inside {ppd_pkg::SEL_NONE, ppd_pkg::SEL_ERR});
      ii = seed[3];
      @(posedge clk_sys);
      io_req <= '{ad, w, !w, d};
      internal_ignore <= ii;
      unit_rdata <= seed[15:8];
      #1 chk(io_sel, es);
      @(posedge clk_sys);
      io_req <= '0;
      #1 chk(io_rdata_oe, dr);
      if (!w && es == ppd_pkg::SEL_SYS) chk(io_rdata, p61);
      if (dr && !(es inside {ppd_pkg::SEL_SYS, ppd_pkg::SEL_FAST}))
         chk(io_rdata, seed[15:8]);
      chk(ignore_numeric_error_output,
         ext ? !(w && es == ppd_pkg::SEL_ERR) : ii);
      if (w && es == ppd_pkg::SEL_SYS) p61 = d;
   endtask
   initial begin
      repeat (5) @(posedge clk_sys);
      reset <= '0;
      apb(0, ppd_pkg::OFS_CTRL, 0);
      chk(rdv, ppd_pkg::CTRL_RESET);
      apb(0, ppd_pkg::OFS_PORT70, 0);
      chk(rdv, ppd_pkg::PORT70_RESET);
      chk(nmi_mask, 1);
      chk(tone_output, 1);
      $display("done reset");
      foreach (tbl[i]) io(tbl[i], 0, 0);
      for (int i = 0; i < 40; i++) begin
         r = xs();
         io({7'h00, r[8:0]}, r[9], r[17:10]);
      end
      apb(0, ppd_pkg::OFS_STATUS, 0);
      chk(rdv[ppd_pkg::ST_UNMAPPED], 1);
      apb(0, 12'h0FC, 0);
      chk(rdv, 0);
      $display("done decode");
      apb(1, ppd_pkg::OFS_MASK, 32'h0000_000F);
      wt(2);
      chk(irq, 1);
      apb(1, ppd_pkg::OFS_STATUS, 32'h0000_000F);
      wt(2);
      chk(irq, 0);
      want <= 4'h6;
      wt(6);
      want <= 4'h0;
      wt(6);
      apb(0, ppd_pkg::OFS_STATUS, 0);
      chk(rdv, 32'h0000_0006);
      chk(irq, 1);
      apb(1, ppd_pkg::OFS_STATUS, 32'h0000_0006);
      $display("done interrupt");
      timer2_out <= '0;
      io(16'h0061, 1, 8'h22);
      wt(2);
      chk(tone_output, 0);
      chk(control_link_out.p61_bit5, 1);
      io(16'h0061, 0, 0);
      io(16'h0061, 1, 8'h00);
      wt(2);
      chk(tone_output, 1);
      chk(control_link_out.p61_bit5, 0);
      link_side_events <= 4'hA;
      wt(6);
      chk(control_link_out[3:0], 4'hA);
      $display("done link");
      io(16'h0092, 1, 8'h02);
      wt(2);
      chk(address_wrap_mask_output, 1);
      io(16'h0092, 1, 8'h00);
      wt(2);
      chk(address_wrap_mask_output, 0);
      io(16'h0092, 1, 8'h01);
      chk(fast_reset, 1);
      wt(1);
      chk(fast_reset, 0);
      address_line_gate <= '1;
      wt(7);
      chk(address_wrap_mask_output, 1);
      address_line_gate <= '0;
      io(16'h0070, 1, 8'h00);
      wt(2);
      chk(nmi_mask, 0);
      $display("done ports");
      for (int i = 0; i < 6; i++) begin
         r = xs();
         apb(1, ppd_pkg::OFS_CTRL, 32'h4 + i % 3);
         irq_pins <= r[15:0];
         rtc_pin_shared_irq_eight <= r[16];
         fpu_error_input <= r[17];
         wt(7);
         ex = r[15:0];
         if (i % 3 == 1) ex[8] = !r[16];
         if (i % 3 == 2) ex[13] = r[17];
         chk(int_lines, ex);
         chk(fpu_error_internal, (i % 3 == 2) ? 0 : r[17]);
         io(16'h00F0 + r[18], 1, r[26:19]);
      end
      $display("done pins");
      power_good_input <= '0;
      rtc_alarm <= '1;
      wt(7);
      chk(alarm_pin_oe, 1);
      chk(alarm_pin_out, 0);
      rtc_alarm <= '0;
      wt(7);
      chk(alarm_pin_oe, 0);
      power_good_input <= '1;
      $display("done alarm");
      finish_test();
   end
endmodule
`default_nettype wire

/* File: rtl/ppd_decode.sv */
// Combinational I/O address decoder for the legacy port map.
// Assumes a stable address during the I/O cycle.
`timescale 1ns/1ps
`default_nettype none
module ppd_decode (
   // Address in
   input wire logic [15:0] addr,
   // Selected block
   output ppd_pkg::ppd_sel_e sel
);
   always_comb begin
      sel = ppd_pkg::SEL_NONE; // RULE_16
      if (addr <= ppd_pkg::P_DMA1_HI)
         sel = ppd_pkg::SEL_DMA1; // RULE_13
      else if (addr[15:1] == ppd_pkg::P_PIC1[15:1])
         sel = ppd_pkg::SEL_PIC1; // RULE_12
      else if (addr[15:1] == ppd_pkg::P_CFG[15:1])
         sel = ppd_pkg::SEL_CFG; // RULE_09
      else if (addr[15:1] == ppd_pkg::P_SMM[15:1])
         sel = ppd_pkg::SEL_SMM; // RULE_09
      else if (addr >= ppd_pkg::P_TMR_LO && addr <= ppd_pkg::P_TMR_HI)
         sel = ppd_pkg::SEL_TMR; // RULE_14
      else if (addr == ppd_pkg::P_KBD)
         sel = ppd_pkg::SEL_KBD; // RULE_14
      else if (addr == ppd_pkg::P_SYS)
         sel = ppd_pkg::SEL_SYS; // RULE_14
      else if (addr == ppd_pkg::P_RTC_ADR)
         sel = ppd_pkg::SEL_RTC_ADR; // RULE_10
      else if (addr == ppd_pkg::P_RTC_DAT)
         sel = ppd_pkg::SEL_RTC_DAT; // RULE_10
      else if (addr >= ppd_pkg::P_PAGE_LO && addr <= ppd_pkg::P_PAGE_HI)
         sel = ppd_pkg::SEL_PAGE; // RULE_13
      else if (addr == ppd_pkg::P_FAST)
         sel = ppd_pkg::SEL_FAST; // RULE_11
      else if (addr[15:1] == ppd_pkg::P_PIC2[15:1])
         sel = ppd_pkg::SEL_PIC2; // RULE_12
      else if (addr >= ppd_pkg::P_DMA2_LO && addr <= ppd_pkg::P_DMA2_HI)
         sel = ppd_pkg::SEL_DMA2; // RULE_13
      else if (addr[15:1] == ppd_pkg::P_ERR[15:1])
         sel = ppd_pkg::SEL_ERR;
   end
endmodule
`default_nettype wire

/* File: rtl/ppd_pkg.sv */
// Constants, port map and carrier types for the legacy port decoder.
// Assumes one 125 MHz clock and an APB master for the control registers.
// Overview of operation
// [RULE_01] External interrupt request inputs are active high and feed the internal controller.
// [RULE_02] With the clock-calendar disabled the crystal pin is an active-low interrupt-8 input.
// [RULE_03] The tone output stays high while the speaker data bit (port 61h bit 1) is zero.
// [RULE_04] The error input goes to internal error logic, or is an active-high interrupt-13 input when external.
// [RULE_05] The ignore-error output comes from internal logic, or is an active-low F0/F1 write strobe when external.
// [RULE_06] While power-good is low the shared error pin is an open-collector alarm output.
// [RULE_07] The control link carries port 61 bit 5, keyboard interrupt, refresh request/complete and address strobe.
// [RULE_08] The system controller sends acknowledge, reset request, refresh acknowledge and keyboard data on the link input.
// [RULE_09] Ports 22-23 and 26-27 decode as the two configuration index/data pairs.
// [RULE_10] Port 70 is the clock-calendar address with NMI mask in bit 7; port 71 its data.
// [RULE_11] Port 92 is the fast reset and fast address-20 gate port.
// [RULE_12] Interrupt controllers sit at 20-21 (lines 0-7) and A0-A1 (lines 8-15).
// [RULE_13] Ports 00-0F, C0-DF and 80-8F decode as 8-bit DMA, 16-bit DMA and page registers.
// [RULE_14] Ports 40-43 timer, 60 keyboard data, 61 system control; 64 is left to the companion.
// [RULE_15] The address-wrap mask output is the OR of the keyboard gate and port 92 bit 1.
// [RULE_16] Accesses outside the decoded ranges are ignored and the data bus stays undriven.
package ppd_pkg;
   // APB register offsets
   localparam logic [11:0] OFS_CTRL = 12'h000;
   localparam logic [11:0] OFS_STATUS = 12'h004;
   localparam logic [11:0] OFS_MASK = 12'h008;
   localparam logic [11:0] OFS_PINS = 12'h00C;
   localparam logic [11:0] OFS_PORT61 = 12'h010;
   localparam logic [11:0] OFS_PORT92 = 12'h014;
   localparam logic [11:0] OFS_PORT70 = 12'h018;
   // Control register fields
   localparam int CTRL_RTC_OFF = 0;
   localparam int CTRL_EXT_ERR = 1;
   localparam int CTRL_INTC_EN = 2;
   // Status bit positions
   localparam int ST_UNMAPPED = 0;
   localparam int ST_RESET_REQ = 1;
   localparam int ST_LINK_ACK = 2;
   localparam int ST_ERR_WR = 3;
   localparam int ST_WIDTH = 4;
   // Reset values
   localparam logic [31:0] CTRL_RESET = 32'h0000_0004;
   localparam logic [7:0] PORT61_RESET = 8'h00;
   localparam logic [7:0] PORT92_RESET = 8'h00;
   localparam logic [7:0] PORT70_RESET = 8'h80;
   // I/O port map
   localparam logic [15:0] P_DMA1_LO = 16'h0000;
   localparam logic [15:0] P_DMA1_HI = 16'h000F;
   localparam logic [15:0] P_PIC1 = 16'h0020;
   localparam logic [15:0] P_CFG = 16'h0022;
   localparam logic [15:0] P_SMM = 16'h0026;
   localparam logic [15:0] P_TMR_LO = 16'h0040;
   localparam logic [15:0] P_TMR_HI = 16'h0043;
   localparam logic [15:0] P_KBD = 16'h0060;
   localparam logic [15:0] P_SYS = 16'h0061;
   localparam logic [15:0] P_KBD_CMD = 16'h0064;
   localparam logic [15:0] P_RTC_ADR = 16'h0070;
   localparam logic [15:0] P_RTC_DAT = 16'h0071;
   localparam logic [15:0] P_PAGE_LO = 16'h0080;
   localparam logic [15:0] P_PAGE_HI = 16'h008F;
   localparam logic [15:0] P_FAST = 16'h0092;
   localparam logic [15:0] P_PIC2 = 16'h00A0;
   localparam logic [15:0] P_DMA2_LO = 16'h00C0;
   localparam logic [15:0] P_DMA2_HI = 16'h00DF;
   localparam logic [15:0] P_ERR = 16'h00F0;
   // Bit positions inside ports
   localparam int P61_SPK_DATA = 1;
   localparam int P61_LINK_BIT = 5;
   localparam int P92_FAST_RST = 0;
   localparam int P92_FAST_GATE = 1;
   localparam int P70_NMI_MASK = 7;
   // Speaker tone half period
   localparam int TONE_HALF_NS = 512;
   localparam int CLK_NS = 8;
   localparam int TONE_HALF_CYC = TONE_HALF_NS / CLK_NS;

   typedef enum logic [4:0] {
      SEL_NONE = 5'h00, SEL_DMA1 = 5'h01, SEL_PIC1 = 5'h02,
      SEL_CFG = 5'h03, SEL_SMM = 5'h04, SEL_TMR = 5'h05,
      SEL_KBD = 5'h06, SEL_SYS = 5'h07, SEL_RTC_ADR = 5'h08,
      SEL_RTC_DAT = 5'h09, SEL_PAGE = 5'h0A, SEL_FAST = 5'h0B,
      SEL_PIC2 = 5'h0C, SEL_DMA2 = 5'h0D, SEL_ERR = 5'h0E
   } ppd_sel_e;

   typedef struct packed {
      logic p61_bit5;
      logic kbd_irq;
      logic refresh_req;
      logic refresh_done;
      logic addr_strobe;
   } ppd_link_out_s;

   typedef struct packed {
      logic int_ack;
      logic reset_req;
      logic refresh_ack;
      logic kbd_info;
   } ppd_link_in_s;

   typedef struct packed {
      logic [15:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } ppd_io_req_s;
endpackage

/* File: rtl/ppd_sync.sv */
// Two-stage synchroniser for asynchronous pin inputs.
// Assumes the input has no relation to clk_sys.
`timescale 1ns/1ps
`default_nettype none
module ppd_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // Data
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] next_stage1;
   logic [WIDTH-1:0] next_q;

   // Refuse an empty bus at elaboration
   if (WIDTH < 1) begin : g_bad_width
      $error("ppd_sync WIDTH must be at least 1");
   end

   always_comb begin
      next_stage1 = d;
      next_q = stage1;
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         stage1 <= '0;
         q <= '0;
      end else begin
         stage1 <= next_stage1;
         q <= next_q;
      end
   end
endmodule
`default_nettype wire

/* File: rtl/ppd_top.sv */
// Legacy port decode, system ports and interrupt pin muxing.
// Assumes an APB master on clk_sys, an I/O cycle strobe from the local
// bus on clk_sys, and asynchronous pins from the board.
`timescale 1ns/1ps
`default_nettype none
module ppd_top (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // I/O cycle from the local bus, one-cycle strobes
   input wire ppd_pkg::ppd_io_req_s io_req,
   output logic [7:0] io_rdata,
   output logic io_rdata_oe,
   output ppd_pkg::ppd_sel_e io_sel,
   // Internal controller read data for ports the block does not hold
   input wire logic [7:0] unit_rdata,
   // Board pins
   input wire logic [15:0] irq_pins,
   input wire logic rtc_pin_shared_irq_eight,
   input wire logic fpu_error_input,
   input wire logic power_good_input,
   input wire logic rtc_alarm,
   input wire logic address_line_gate,
   input wire logic [3:0] link_side_events,
   // Internal error logic
   input wire logic internal_ignore,
   // Outputs to the interrupt controller and pins, and the timer2_out tone input
   output logic [15:0] int_lines,
   output logic fpu_error_internal,
   output logic ignore_numeric_error_output,
   output logic alarm_pin_out,
   output logic alarm_pin_oe,
   output logic tone_output,
   input wire logic timer2_out,
   output logic address_wrap_mask_output,
   output logic fast_reset,
   output logic nmi_mask,
   // Control link
   output ppd_pkg::ppd_link_out_s control_link_out,
   input wire ppd_pkg::ppd_link_in_s control_link_in,
   // Interrupt
   output logic irq
);
   localparam int NS = ppd_pkg::ST_WIDTH;

   logic [15:0] irq_s;
   logic rtc_pin_s, fpu_error_input_s, pgood_s, alarm_s, gate_s;
   logic [3:0] link_ev_s;
   logic [3:0] link_in_s;

   ppd_sync #(.WIDTH(16)) u_sync_irq (
      .clk_sys(clk_sys), .reset(reset), .d(irq_pins), .q(irq_s));
   ppd_sync #(.WIDTH(5)) u_sync_misc (
      .clk_sys(clk_sys), .reset(reset),
      .d({rtc_pin_shared_irq_eight, fpu_error_input, power_good_input,
          rtc_alarm, address_line_gate}),
      .q({rtc_pin_s, fpu_error_input_s, pgood_s, alarm_s, gate_s}));
   ppd_sync #(.WIDTH(8)) u_sync_link (
      .clk_sys(clk_sys), .reset(reset),
      .d({link_side_events, control_link_in}),
      .q({link_ev_s, link_in_s}));

   ppd_pkg::ppd_sel_e sel;
   ppd_decode u_dec (.addr(io_req.addr), .sel(sel));

   // Register state
   logic [31:0] ctrl, next_ctrl;
   logic [NS-1:0] status, next_status, mask, next_mask;
   logic [7:0] port61, next_port61, port92, next_port92;
   logic [7:0] port70, next_port70;
   logic [7:0] io_rdata_n;
   logic io_rdata_oe_n;
   logic [31:0] next_prdata;
   logic next_err_strobe, err_strobe;
   logic [15:0] tone_cnt, next_tone_cnt;
   logic tone_sq, next_tone_sq;

   wire apb_wr = psel && penable && pwrite;
   wire apb_rd = psel && !penable && !pwrite;
   wire io_any = io_req.wr || io_req.rd;
   wire ext_err = ctrl[ppd_pkg::CTRL_EXT_ERR];
   wire rtc_off = ctrl[ppd_pkg::CTRL_RTC_OFF];

   logic [NS-1:0] ev;
   always_comb begin
      ev = '0;
      ev[ppd_pkg::ST_UNMAPPED] = io_any && sel == ppd_pkg::SEL_NONE;
      ev[ppd_pkg::ST_RESET_REQ] = link_in_s[2];
      ev[ppd_pkg::ST_LINK_ACK] = link_in_s[1];
      ev[ppd_pkg::ST_ERR_WR] = io_req.wr && sel == ppd_pkg::SEL_ERR;
   end

   always_comb begin
      next_ctrl = ctrl;
      next_mask = mask;
      next_status = status;
      next_prdata = 32'h0000_0000;
      next_port61 = port61;
      next_port92 = port92;
      next_port70 = port70;
      if (apb_wr) begin
         case (paddr)
            ppd_pkg::OFS_CTRL: next_ctrl = {29'h0, pwdata[2:0]};
            ppd_pkg::OFS_MASK: next_mask = pwdata[NS-1:0];
            ppd_pkg::OFS_STATUS: next_status = status & ~pwdata[NS-1:0];
            default: next_ctrl = ctrl;
         endcase
      end
      // Set beats clear in the same cycle
      next_status = next_status | ev;
      if (apb_rd) begin
         case (paddr)
            ppd_pkg::OFS_CTRL: next_prdata = ctrl;
            ppd_pkg::OFS_STATUS: next_prdata = {28'h0, status};
            ppd_pkg::OFS_MASK: next_prdata = {28'h0, mask};
            ppd_pkg::OFS_PINS: next_prdata = {24'h0, pgood_s, fpu_error_input_s,
               rtc_pin_s, alarm_s, gate_s, link_in_s[3:1]};
            ppd_pkg::OFS_PORT61: next_prdata = {24'h0, port61};
            ppd_pkg::OFS_PORT92: next_prdata = {24'h0, port92};
            ppd_pkg::OFS_PORT70: next_prdata = {24'h0, port70};
            default: next_prdata = 32'h0000_0000;
         endcase
      end
      if (io_req.wr) begin
         case (sel)
            ppd_pkg::SEL_SYS: next_port61 = io_req.wdata; // RULE_14
            ppd_pkg::SEL_FAST: next_port92 = io_req.wdata; // RULE_11
            ppd_pkg::SEL_RTC_ADR: next_port70 = io_req.wdata; // RULE_10
            default: next_port61 = port61;
         endcase
      end
      // Fast reset bit self-clears after one pulse
      if (port92[ppd_pkg::P92_FAST_RST] && !(io_req.wr &&
          sel == ppd_pkg::SEL_FAST))
         next_port92[ppd_pkg::P92_FAST_RST] = 1'b0; // RULE_11
   end

   // I/O read data; undriven for unmapped ports
   always_comb begin
      io_rdata_n = 8'h00;
      io_rdata_oe_n = 1'b0;
      if (io_req.rd) begin
         io_rdata_oe_n = sel != ppd_pkg::SEL_NONE &&
            sel != ppd_pkg::SEL_ERR; // RULE_16
         case (sel)
            ppd_pkg::SEL_SYS: io_rdata_n = port61; // RULE_14
            ppd_pkg::SEL_FAST: io_rdata_n = port92; // RULE_11
            ppd_pkg::SEL_NONE: io_rdata_n = 8'h00; // RULE_16
            ppd_pkg::SEL_ERR: io_rdata_n = 8'h00;
            default: io_rdata_n = unit_rdata;
         endcase
      end
   end

   // Speaker square wave, ANDed with the timer output while the speaker data bit is set
   always_comb begin
      next_tone_cnt = tone_cnt + 16'h0001;
      next_tone_sq = tone_sq;
      if (tone_cnt == 16'(ppd_pkg::TONE_HALF_CYC - 1)) begin
         next_tone_cnt = 16'h0000;
         next_tone_sq = ~tone_sq;
      end
      next_err_strobe = io_req.wr && sel == ppd_pkg::SEL_ERR;
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         ctrl <= ppd_pkg::CTRL_RESET;
         status <= '0;
         mask <= '0;
         prdata <= 32'h0000_0000;
         port61 <= ppd_pkg::PORT61_RESET;
         port92 <= ppd_pkg::PORT92_RESET;
         port70 <= ppd_pkg::PORT70_RESET;
         io_rdata <= 8'h00;
         io_rdata_oe <= 1'b0;
         err_strobe <= 1'b0;
         tone_cnt <= 16'h0000;
         tone_sq <= 1'b0;
      end else begin
         ctrl <= next_ctrl;
         status <= next_status;
         mask <= next_mask;
         prdata <= next_prdata;
         port61 <= next_port61;
         port92 <= next_port92;
         port70 <= next_port70;
         io_rdata <= io_rdata_n;
         io_rdata_oe <= io_rdata_oe_n;
         err_strobe <= next_err_strobe;
         tone_cnt <= next_tone_cnt;
         tone_sq <= next_tone_sq;
      end
   end

   always_comb begin
      pready = 1'b1;
      pslverr = 1'b0;
      io_sel = sel;
      irq = |(status & mask);
      // External lines pass through the two-stage synchroniser, active high
      int_lines = irq_s; // RULE_01
      int_lines[13] = ext_err ? fpu_error_input_s : irq_s[13]; // RULE_04
      if (rtc_off)
         int_lines[8] = ~rtc_pin_s; // RULE_02
      else
         int_lines[8] = irq_s[8];
      fpu_error_internal = ext_err ? 1'b0 : fpu_error_input_s; // RULE_04
      ignore_numeric_error_output = ext_err ? ~err_strobe
         : internal_ignore; // RULE_05
      alarm_pin_out = 1'b0;
      alarm_pin_oe = !pgood_s && alarm_s; // RULE_06
      tone_output = port61[ppd_pkg::P61_SPK_DATA]
         ? (timer2_out & tone_sq) : 1'b1; // RULE_03
      address_wrap_mask_output = gate_s |
         port92[ppd_pkg::P92_FAST_GATE]; // RULE_15
      fast_reset = port92[ppd_pkg::P92_FAST_RST];
      nmi_mask = port70[ppd_pkg::P70_NMI_MASK]; // RULE_10
      control_link_out.p61_bit5 = port61[ppd_pkg::P61_LINK_BIT]; // RULE_07
      control_link_out.kbd_irq = link_ev_s[3]; // RULE_07
      control_link_out.refresh_req = link_ev_s[2];
      control_link_out.refresh_done = link_ev_s[1];
      control_link_out.addr_strobe = link_ev_s[0];
   end
endmodule
`default_nettype wire
